// ---- include/pacp_pkg.sv ----
// constants, types and helpers shared by the command parser and its result store
package pacp_pkg;

    // ****************************************************************
    // characters
    // ****************************************************************
    localparam logic [7:0] CHR_CR = 8'h0D;
    localparam logic [7:0] CHR_ESC = 8'h1B;
    localparam logic [7:0] CHR_BAR = 8'h7C;
    localparam logic [7:0] CHR_BANG = 8'h21;
    localparam logic [7:0] CHR_SP = 8'h20;
    localparam logic [7:0] CHR_MINUS = 8'h2D;
    localparam logic [7:0] CHR_COMMA = 8'h2C;
    localparam logic [7:0] CHR_A = 8'h41;
    localparam logic [7:0] CHR_C = 8'h43;
    localparam logic [7:0] CHR_P = 8'h50;
    localparam logic [7:0] CHR_R = 8'h52;

    // ****************************************************************
    // limits and sizes
    // ****************************************************************
    localparam logic [15:0] MAX_CONV = 16'h2710;
    localparam logic [7:0] MAX_CHAN = 8'h07;
    localparam int STORE_DEPTH = 10000;
    localparam int STORE_AW = 14;
    localparam int LINE_MAX = 16;
    localparam logic [4:0] LINE_FULL = 5'h10;
    localparam logic [4:0] LEN_SINGLE = 5'h05;
    localparam logic [4:0] LEN_RANGE = 5'h0B;
    localparam logic [4:0] LEN_ADDR = 5'h03;

    // ****************************************************************
    // replies
    // ****************************************************************
    localparam logic [7:0] ERR_CHAN = 8'h31;
    localparam logic [7:0] ERR_SYNTAX = 8'h33;
    localparam logic [7:0] ERR_TASK = 8'h34;
    localparam logic [7:0] ERR_PARITY = 8'h39;
    localparam logic [8*8-1:0] TXT_PROG = "PROGRAM=";
    localparam int LEN_UNREC = 29;
    localparam logic [8*LEN_UNREC-1:0] TXT_UNREC = "Error, Unrecognized Command: ";
    localparam int LEN_PART = 37;
    localparam logic [8*LEN_PART-1:0] TXT_PART = "Error, Command not fully recognized: ";
    localparam int LEN_ADDRMSG = 44;
    localparam logic [8*LEN_ADDRMSG-1:0] TXT_ADDR =
        "Error, Address command must be CR terminated";

    typedef enum logic [2:0] {
        ST_RECV = 3'h0,
        ST_EXEC = 3'h1,
        ST_ACQ = 3'h3,
        ST_SEND = 3'h2,
        ST_DATA = 3'h6,
        ST_FWLD = 3'h4
    } pacp_state_t;

    typedef enum logic [2:0] {
        MSG_NONE, MSG_UNREC, MSG_PART, MSG_ADDR, MSG_CODE
    } pacp_msg_t;

    typedef enum logic [2:0] {
        ACT_REPLY, ACT_DROP, ACT_LIST, ACT_SINGLE, ACT_READ, ACT_FW
    } pacp_act_t;

    // {valid, nibble} of one ascii hex digit
    function automatic logic [4:0] hex_nib(input logic [7:0] c);
        if (c >= 8'h30 && c <= 8'h39) return {1'b1, 4'(c - 8'h30)};
        if (c >= 8'h41 && c <= 8'h46) return {1'b1, 4'(c - 8'h37)};
        if (c >= 8'h61 && c <= 8'h66) return {1'b1, 4'(c - 8'h57)};
        return 5'h00;
    endfunction : hex_nib

    function automatic logic [7:0] hex_chr(input logic [3:0] n);
        return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : hex_chr

endpackage : pacp_pkg

// ---- logic/pacp_store.sv ----
// result store: one word per list-acquire conversion (single acquires are not stored), point number above result
`timescale 1ns/1ps
module pacp_store #(
    parameter int DEPTH = pacp_pkg::STORE_DEPTH,
    parameter int AW = pacp_pkg::STORE_AW,
    parameter int W = 24
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [W-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [W-1:0] rd_data
);
    import pacp_pkg::*;

    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        rd_data <= mem[rd_addr];
    end

endmodule : pacp_store

// ---- logic/pacp_parser.sv ----
// ascii command parser for the acquisition pod
`timescale 1ns/1ps
// Function
// - after firmware-load entry, escape restarts the pod as at power-on
// - vertical bar enters firmware load, only as first byte after reset
// - list acquire returns no data, stores every result internally
// - readback sends entries of point and result hex, spaces, final CR
// - readback entry count equals count of latest list acquire
// - single acquire converts one channel with given config, replies at once
// - foreground acquire takes list parameters, runs exclusively at full rate
// - error 1 for non-hex channel or channel above 07
// - error 3 for improper syntax such as missing parameters
// - error 4 when channel is unfit for the operation
// - error 9 when any byte of a command other than address select had parity or framing error
// - unknown command gives Error text echoing command, ending in CR
// - valid P or R first letter but bad rest gives not-fully-recognised text
// - extra characters after address select give CR-terminated error text
// - hex bytes are sent most significant nibble first
// - once selected, respond to all commands until another select
module pacp_parser #(
    parameter int DEPTH = pacp_pkg::STORE_DEPTH,
    parameter int AW = pacp_pkg::STORE_AW
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] pod_addr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_err,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic conv_req,
    output logic [7:0] conv_point,
    output logic [15:0] conv_cfg,
    output logic conv_direct,
    output logic conv_fast,
    input wire logic conv_done,
    input wire logic [15:0] conv_data,
    output logic fw_mode,
    output logic restart_req
);
    import pacp_pkg::*;

    pacp_state_t state;
    pacp_msg_t msg;
    logic [7:0] code;
    logic [7:0] line [LINE_MAX];
    logic [4:0] len, echo_len;
    logic line_err, just_reset, selected, single;
    logic [15:0] single_res, acq_cnt, acq_idx, last_cnt, ei;
    logic [7:0] first_pt, last_pt;
    logic [6:0] pos;
    logic [2:0] di;
    logic rd_wait, fresh;
    logic [23:0] rd_word;

    function automatic logic [8:0] hex2(input logic [7:0] hi, input logic [7:0] lo);
        logic [4:0] h;
        logic [4:0] l;
        h = hex_nib(hi);
        l = hex_nib(lo);
        return {h[4] & l[4], h[3:0], l[3:0]};
    endfunction : hex2

    // ****************************************************************
    // line collection
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            len <= 5'h00;
            line_err <= 1'b0;
        end else if (restart_req || state == ST_EXEC) begin
            len <= 5'h00;
            line_err <= 1'b0;
        end else if (state == ST_RECV && rx_valid) begin
            line_err <= line_err | rx_err;
            if (rx_data != CHR_CR && len < LINE_FULL) begin
                line[len[3:0]] <= rx_data;
                len <= len + 5'h01;
            end
        end
    end

    // ****************************************************************
    // command decode
    // ****************************************************************
    logic is_ac, is_range, prog_ok, resp_en, next_sel;
    logic [3:0] off;
    logic [8:0] p_n1, p_n2, p_c1, p_c2, p_cfg, p_ch;
    logic [15:0] cnt;
    pacp_act_t ex_act;
    pacp_msg_t ex_msg;
    logic [7:0] ex_code;

    always_comb begin
        is_ac = (line[1] == CHR_C);
        off = is_ac ? 4'h1 : 4'h0;
        is_range = is_ac || (line[3] == CHR_MINUS);
        p_n1 = hex2(line[4'h1 + off], line[4'h2 + off]);
        p_n2 = hex2(line[4'h4 + off], line[4'h5 + off]);
        p_c1 = hex2(line[4'h7 + off], line[4'h8 + off]);
        p_c2 = hex2(line[4'h9 + off], line[4'hA + off]);
        cnt = {p_c1[7:0], p_c2[7:0]};
        p_cfg = hex2(line[1], line[2]);
        p_ch = hex2(line[3], line[4]);
        prog_ok = 1'b1;
        for (int i = 0; i < 7; i++) begin
            prog_ok = prog_ok & (line[i] == TXT_PROG[8*(7-i) +: 8]);
        end
        resp_en = (pod_addr == 8'h00) || selected;
        next_sel = selected;
        ex_act = ACT_REPLY;
        ex_msg = MSG_NONE;
        ex_code = ERR_SYNTAX;
        if (line[0] == CHR_BANG && len >= LEN_ADDR && p_cfg[8]) begin
            if (p_cfg[7:0] == pod_addr) begin
                next_sel = 1'b1;
                if (len != LEN_ADDR) begin
                    ex_msg = MSG_ADDR;
                end
            end else begin
                next_sel = 1'b0;
                ex_act = ACT_DROP;
            end
        end else if (!resp_en) begin
            ex_act = ACT_DROP;
        end else if (line_err) begin
            ex_msg = MSG_CODE;
            ex_code = ERR_PARITY;
        end else if (len != 5'h00) begin
            case (line[0])
                CHR_BANG: ex_msg = MSG_CODE;
                CHR_P: begin
                    if (prog_ok && (len == 5'h07 || (len == 5'h08 && line[7] == TXT_PROG[7:0])))
                    begin
                        ex_act = ACT_FW;
                    end else begin
                        ex_msg = MSG_PART;
                    end
                end
                CHR_R: begin
                    if (len == 5'h01) begin
                        ex_act = ACT_READ;
                    end else begin
                        ex_msg = MSG_PART;
                    end
                end
                CHR_A: begin
                    ex_msg = MSG_CODE;
                    if (len > 5'h01 && is_range) begin
                        if (len != LEN_RANGE + {1'b0, off} || line[4'h3 + off] != CHR_MINUS
                            || line[4'h6 + off] != CHR_COMMA) begin
                            ex_code = ERR_SYNTAX;
                        end else if (!p_n1[8] || !p_n2[8] || p_n1[7:0] > MAX_CHAN
                            || p_n2[7:0] > MAX_CHAN) begin
                            ex_code = ERR_CHAN;
                        end else if (p_n1[7:0] > p_n2[7:0]) begin
                            ex_code = ERR_TASK;
                        end else if (!p_c1[8] || !p_c2[8] || cnt > MAX_CONV) begin
                            ex_code = ERR_SYNTAX;
                        end else begin
                            ex_act = ACT_LIST;
                            ex_msg = MSG_NONE;
                        end
                    end else if (len == LEN_SINGLE) begin
                        if (!p_cfg[8]) begin
                            ex_code = ERR_SYNTAX;
                        end else if (!p_ch[8] || p_ch[7:0] > MAX_CHAN) begin
                            ex_code = ERR_CHAN;
                        end else begin
                            ex_act = ACT_SINGLE;
                            ex_msg = MSG_NONE;
                        end
                    end
                end
                default: ex_msg = MSG_UNREC;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            selected <= 1'b0;
        end else if (restart_req) begin
            selected <= 1'b0;
        end else if (state == ST_EXEC) begin
            selected <= next_sel;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    logic load, send_last, data_go, data_last;
    assign load = !tx_valid || tx_ready;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state <= ST_RECV;
            msg <= MSG_NONE;
            code <= ERR_SYNTAX;
            echo_len <= 5'h00;
            single <= 1'b0;
            single_res <= 16'h0000;
            first_pt <= 8'h00;
            last_pt <= 8'h00;
            conv_point <= 8'h00;
            conv_cfg <= 16'h0000;
            conv_req <= 1'b0;
            conv_direct <= 1'b0;
            conv_fast <= 1'b0;
            acq_cnt <= 16'h0000;
            acq_idx <= 16'h0000;
            last_cnt <= 16'h0000;
            fw_mode <= 1'b0;
            restart_req <= 1'b0;
            just_reset <= 1'b1;
        end else if (restart_req) begin
            state <= ST_RECV;
            conv_req <= 1'b0;
            last_cnt <= 16'h0000;
            fw_mode <= 1'b0;
            restart_req <= 1'b0;
            just_reset <= 1'b1;
        end else begin
            case (state)
                ST_RECV: begin
                    if (rx_valid) begin
                        just_reset <= 1'b0;
                        if (just_reset && len == 5'h00 && rx_data == CHR_BAR) begin
                            fw_mode <= 1'b1;
                            state <= ST_FWLD;
                        end else if (rx_data == CHR_CR) begin
                            state <= ST_EXEC;
                        end
                    end
                end
                ST_EXEC: begin
                    echo_len <= len;
                    msg <= ex_msg;
                    code <= ex_code;
                    single <= 1'b0;
                    case (ex_act)
                        ACT_DROP: state <= ST_RECV;
                        ACT_LIST: begin
                            first_pt <= p_n1[7:0];
                            last_pt <= p_n2[7:0];
                            conv_point <= p_n1[7:0];
                            acq_cnt <= cnt;
                            acq_idx <= 16'h0000;
                            conv_fast <= !is_ac;
                            conv_direct <= 1'b0;
                            conv_req <= (cnt != 16'h0000);
                            state <= ST_ACQ;
                        end
                        ACT_SINGLE: begin
                            single <= 1'b1;
                            conv_point <= p_ch[7:0];
                            conv_cfg <= {p_cfg[7:0], p_ch[7:0]};
                            conv_direct <= 1'b1;
                            conv_fast <= 1'b0;
                            conv_req <= 1'b1;
                            state <= ST_ACQ;
                        end
                        ACT_READ: state <= ST_DATA;
                        ACT_FW: begin
                            fw_mode <= 1'b1;
                            state <= ST_FWLD;
                        end
                        default: state <= ST_SEND;
                    endcase
                end
                ST_ACQ: begin
                    if (single) begin
                        if (conv_done) begin
                            single_res <= conv_data;
                            conv_req <= 1'b0;
                            state <= ST_DATA;
                        end
                    end else if (acq_idx == acq_cnt) begin
                        last_cnt <= acq_cnt;
                        conv_req <= 1'b0;
                        msg <= MSG_NONE;
                        state <= ST_SEND;
                    end else if (conv_done) begin
                        acq_idx <= acq_idx + 16'h0001;
                        conv_point <= (conv_point == last_pt) ? first_pt : conv_point + 8'h01;
                        if (acq_idx == acq_cnt - 16'h0001) begin
                            conv_req <= 1'b0;
                        end
                    end
                end
                ST_SEND: begin
                    if (send_last) begin
                        state <= ST_RECV;
                    end
                end
                ST_DATA: begin
                    if (data_last) begin
                        state <= ST_RECV;
                    end
                end
                ST_FWLD: begin
                    if (rx_valid && rx_data == CHR_ESC) begin
                        restart_req <= 1'b1;
                    end
                end
                default: state <= ST_RECV;
            endcase
        end
    end

    pacp_store #(
        .DEPTH(DEPTH),
        .AW(AW),
        .W(24)
    ) u_store (
        .clk_sys(clk_sys),
        .wr_en(state == ST_ACQ && !single && conv_done && acq_idx != acq_cnt),
        .wr_addr(acq_idx[AW-1:0]),
        .wr_data({conv_point, conv_data}),
        .rd_addr(ei[AW-1:0]),
        .rd_data(rd_word)
    );

    // ****************************************************************
    // transmit
    // ****************************************************************
    logic [5:0] pre_len;
    logic [6:0] total;
    logic [7:0] send_char, data_char;
    logic [23:0] word;
    logic [4:0] sh;
    logic entry_last;

    always_comb begin
        case (msg)
            MSG_UNREC: pre_len = 6'(LEN_UNREC);
            MSG_PART: pre_len = 6'(LEN_PART);
            MSG_ADDR: pre_len = 6'(LEN_ADDRMSG);
            MSG_CODE: pre_len = 6'h01;
            default: pre_len = 6'h00;
        endcase
        total = {1'b0, pre_len} + 7'h01;
        if (msg == MSG_UNREC || msg == MSG_PART) begin
            total = total + {2'b00, echo_len};
        end
        send_char = CHR_CR;
        if (pos < {1'b0, pre_len}) begin
            case (msg)
                MSG_UNREC: send_char = TXT_UNREC[8*(LEN_UNREC-1-int'(pos)) +: 8];
                MSG_PART: send_char = TXT_PART[8*(LEN_PART-1-int'(pos)) +: 8];
                MSG_ADDR: send_char = TXT_ADDR[8*(LEN_ADDRMSG-1-int'(pos)) +: 8];
                default: send_char = code;
            endcase
        end else if (pos < total - 7'h01) begin
            send_char = line[4'(pos - {1'b0, pre_len})];
        end
        send_last = (state == ST_SEND) && load && (pos == total - 7'h01);
        word = single ? {8'h00, single_res} : rd_word;
        sh = 5'h14 - {di, 2'b00};
        entry_last = single || (ei + 16'h0001 >= last_cnt);
        data_char = (di == 3'h6) ? (entry_last ? CHR_CR : CHR_SP)
                                 : hex_chr(4'(word >> sh));
        data_go = (state == ST_DATA) && load && !rd_wait && !fresh;
        data_last = data_go && (di == 3'h6) && entry_last;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            pos <= 7'h00;
            ei <= 16'h0000;
            di <= 3'h0;
            rd_wait <= 1'b1;
            fresh <= 1'b1;
        end else if (restart_req) begin
            tx_valid <= 1'b0;
            pos <= 7'h00;
        end else begin
            if (tx_valid && tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (state == ST_SEND) begin
                if (load) begin
                    tx_data <= send_char;
                    tx_valid <= 1'b1;
                    pos <= pos + 7'h01;
                end
            end else begin
                pos <= 7'h00;
            end
            if (state != ST_DATA) begin
                ei <= 16'h0000;
                rd_wait <= 1'b1;
                fresh <= 1'b1;
            end else if (fresh) begin
                fresh <= 1'b0;
                rd_wait <= 1'b0;
                di <= single ? 3'h2 : ((last_cnt == 16'h0000) ? 3'h6 : 3'h0);
            end else if (rd_wait) begin
                rd_wait <= 1'b0;
            end else if (data_go) begin
                tx_data <= data_char;
                tx_valid <= 1'b1;
                if (di == 3'h6) begin
                    di <= 3'h0;
                    ei <= ei + 16'h0001;
                    rd_wait <= 1'b1;
                end else begin
                    di <= di + 3'h1;
                end
            end
        end
    end

endmodule : pacp_parser

// ---- sim/pacp_chk.sv ----
// port assertions for the command parser
`timescale 1ns/1ps
module pacp_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic conv_req,
    input wire logic [7:0] conv_point,
    input wire logic [15:0] conv_cfg,
    input wire logic conv_direct,
    input wire logic conv_fast,
    input wire logic conv_done,
    input wire logic fw_mode,
    input wire logic restart_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply byte dropped before acceptance");
    esc_restart_a: assert property (
        fw_mode && rx_valid && rx_data == 8'h1B |-> ##[1:3] restart_req)
        else $error("escape in firmware mode gave no restart");
    restart_src_a: assert property (restart_req |-> fw_mode)
        else $error("restart outside firmware mode");
    restart_clear_a: assert property (
        restart_req |=> !fw_mode && !tx_valid && !conv_req)
        else $error("restart left state behind");
    list_quiet_a: assert property (conv_req |-> !tx_valid)
        else $error("reply sent during acquisition");
    conv_hold_a: assert property (
        conv_req && !conv_done |=> $stable(conv_point) && $stable(conv_fast))
        else $error("conversion request changed without completion");
    single_chan_a: assert property (conv_req && conv_direct |-> conv_cfg[7:0] <= 8'h07)
        else $error("single acquire on invalid channel");
    fw_idle_a: assert property (fw_mode |-> !conv_req)
        else $error("conversion while in firmware mode");
endmodule : pacp_chk
bind pacp_parser pacp_chk u_chk (
    .clk_sys(clk_sys), .rstn(rstn), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .conv_req(conv_req),
    .conv_point(conv_point), .conv_cfg(conv_cfg), .conv_direct(conv_direct),
    .conv_fast(conv_fast), .conv_done(conv_done), .fw_mode(fw_mode), .restart_req(restart_req)
);

// ---- sim/pacp_host.sv ----
// host and converter model facing the command parser
`timescale 1ns/1ps
module pacp_host (
    input wire logic clk_sys,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_err,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    input wire logic conv_req,
    input wire logic [7:0] conv_point,
    output logic conv_done,
    output logic [15:0] conv_data
);
    byte unsigned txq[$];
    logic [23:0] convq[$];
    initial begin
        {rx_valid, rx_err, tx_ready, conv_done} = 4'h0;
        rx_data = 8'h00;
        conv_data = 16'h0000;
    end
    // parameters are hex ascii, counts kept within the store
    task automatic send(input string s, input int bad);
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_sys);
            rx_valid <= 1'b1;
            rx_data <= s[i];
            rx_err <= (i == bad);
            @(posedge clk_sys);
            rx_valid <= 1'b0;
            rx_data <= ~s[i];
        end
    endtask : send
    // stalls the reply stream, finishes conversions at random
    always @(posedge clk_sys) begin
        if (tx_valid && tx_ready) txq.push_back(tx_data);
        if (conv_done) convq.push_back({conv_point, conv_data});
        tx_ready <= ($urandom % 3) != 0;
        conv_done <= conv_req && !conv_done && ($urandom % 4 == 0);
        conv_data <= 16'($urandom);
    end
endmodule : pacp_host

// ---- sim/pod_acquire_command_parser_tb.sv ----
// self-checking bench for the pod command parser
`timescale 1ns/1ps
module pod_acquire_command_parser_tb;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic rx_valid, rx_err, tx_valid, tx_ready, conv_req, conv_direct, conv_fast;
    logic conv_done, fw_mode, restart_req, fast_seen = 1'b0;
    logic [7:0] rx_data, tx_data, conv_point, pod_addr = 8'h00;
    logic [15:0] conv_cfg, conv_data;
    int errors = 0;
    int check_count = 0;
    int restarts = 0;
    int base;
    string got, exp_s;
    string fw_cmd[3] = '{"|", "|", "PROGRAM=\015"};
    string bad_cmd[4] = '{"A000G\015", "AC02-01,0001\015", "A00\015", "AC00-01,2711\015"};
    string bad_rep[4] = '{"1\015", "4\015", "3\015", "3\015"};
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        restarts <= restarts + int'(restart_req);
        fast_seen <= fast_seen | (conv_req & conv_fast);
    end
    pacp_parser #(.DEPTH(64), .AW(6)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .pod_addr(pod_addr), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_err(rx_err), .tx_valid(tx_valid), .tx_data(tx_data),
        .tx_ready(tx_ready), .conv_req(conv_req), .conv_point(conv_point),
        .conv_cfg(conv_cfg), .conv_direct(conv_direct), .conv_fast(conv_fast),
        .conv_done(conv_done), .conv_data(conv_data), .fw_mode(fw_mode),
        .restart_req(restart_req)
    );
    pacp_host host (
        .clk_sys(clk_sys), .rx_valid(rx_valid), .rx_data(rx_data), .rx_err(rx_err),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .conv_req(conv_req),
        .conv_point(conv_point), .conv_done(conv_done), .conv_data(conv_data)
    );
    task automatic cmp_str(input string what, input string exp, input string seen);
        check_count++;
        if (exp != seen) begin
            errors++;
            $display("unexpected %s: expected %s seen %s", what, exp, seen);
        end
    endtask : cmp_str
    task automatic cmp_bit(input string what, input logic exp, input logic seen);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %b seen %b", what, exp, seen);
        end
    endtask : cmp_bit
    task automatic run(input string s, input int bad, output string r);
        host.txq.delete();
        host.send(s, bad);
        r = "";
        for (int i = 0; i < 5000; i++) begin
            if (host.txq.size() > 0 && host.txq[$] == 8'h0D) break;
            @(posedge clk_sys);
        end
        foreach (host.txq[i]) r = {r, string'(host.txq[i])};
    endtask : run
    task automatic ask(input string s, input int bad, input string exp);
        run(s, bad, got);
        cmp_str(s, exp, got);
    endtask : ask
    // expected readback: points cycle first..last, results as converted
    function automatic string entries(int first, int last, int n, int b);
        string s = "";
        for (int i = 0; i < n; i++) begin
            s = {s, (i > 0) ? " " : "", $sformatf("%02h", first + i % (last - first + 1))};
            s = {s, $sformatf("%04h", host.convq[b + i][15:0])};
        end
        return {s.toupper(), "\015"};
    endfunction : entries
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #400000;
        errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h880B));
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            host.send(fw_cmd[k], -1);
            repeat (3) @(posedge clk_sys);
            cmp_bit("fw_mode", 1'b1, fw_mode);
            host.send("\033", -1);
            repeat (4) @(posedge clk_sys);
            cmp_bit("restart", 1'b1, logic'(restarts == k + 1));
            cmp_bit("fw_mode", 1'b0, fw_mode);
        end
        $display("test firmware done");
        ask("R\015", -1, "\015");
        ask("|\015", -1, "Error, Unrecognized Command: |\015");
        ask("X7\015", -1, "Error, Unrecognized Command: X7\015");
        ask("RZ\015", -1, "Error, Command not fully recognized: RZ\015");
        ask("!00Q\015", -1, "Error, Address command must be CR terminated\015");
        ask("A0003\015", 2, "9\015");
        foreach (bad_cmd[i]) ask(bad_cmd[i], -1, bad_rep[i]);
        pod_addr <= 8'h5C;
        ask("!11\015", -1, "");
        ask("X\015", -1, "");
        ask("!5C\015", -1, "\015");
        ask("X\015", -1, "Error, Unrecognized Command: X\015");
        $display("test errors done");
        run("A5A03\015", -1, got);
        exp_s = $sformatf("%04h", host.convq[$][15:0]);
        cmp_str("single", {exp_s.toupper(), "\015"}, got);
        cmp_bit("cfg", 1'b1, logic'(conv_cfg == 16'h5A03));
        $display("test single done");
        base = host.convq.size();
        ask("AC00-01,0003\015", -1, "\015");
        ask("R\015", -1, entries(0, 1, 3, base));
        base = host.convq.size();
        ask("A01-03,0002\015", -1, "\015");
        cmp_bit("fast", 1'b1, fast_seen);
        ask("R\015", -1, entries(1, 3, 2, base));
        $display("test acquire done");
        give_verdict();
    end
endmodule : pod_acquire_command_parser_tb
